// ===== ebt_timer.sv
// How it works
// - count clock comes from a 10-bit prescaler on system clock or doubled rc clock
// - clock select field picks internal division ratio or external source
// - ceiling is 0xFF or compare A; counter clears or turns down there
// - floor is 0x00 and the counter counts upward from it
// - count equal to compare A or B sets the matching compare flag
// - a compare match clears, sets or toggles that channel's waveform output
// - dead-time enable delays waveform turn-on by dead_time_register count clocks
// - output mode field zero stops driving that waveform output
// - selected one of 6 shutdown triggers clears both output mode fields
// - counter overflow sets the overflow flag
// - pwm modes buffer compare writes; normal and match-clear write directly
// - buffered compares move to both active compares together when the count reaches top
// - six mode codes from the 3-bit waveform mode field split over control a and b
// - normal mode code 0 counts up to 0xFF then wraps to zero
// - normal mode sets overflow in the count clock where count returns to zero
// - the prescaler may be shared with the second timer
// - mode code 2 clears the counter when it equals compare A
// - mode codes 3 and 7 are fast pwm with ceiling 0xFF or compare A
// - mode codes 1 and 5 are phase-correct pwm, up then down
`timescale 1ns/1ps
module ebt_timer (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic doubled_rc_clock,
   input wire logic ext_count_pin,
   input wire logic [5:0] shutdown_trig,
   input wire logic [4:0] second_timer_taps,
   output logic [4:0] prescale_taps,
   output logic waveform_out_a,
   output logic waveform_out_a_oe,
   output logic waveform_out_b,
   output logic waveform_out_b_oe
);
   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [7:0] cnt;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
      logic [7:0] buf_a;
      logic [7:0] buf_b;
      logic [7:0] dead;
      logic [7:0] shut;
      logic [2:0] flags;
      logic dir_down;
      logic wave_a;
      logic wave_b;
      logic [31:0] rdata;
      logic [1:0] ext_sync;
      logic ext_prev;
      logic [1:0] rc_sync;
      logic rc_prev;
      logic [5:0] trig_s1;
      logic [5:0] trig_s2;
   } ebt_state_s;

   ebt_state_s st_reg;
   ebt_state_s st_next;
   ebt_tick_if tk ();

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic ebt_is_fast(input logic [2:0] mode);
      return mode == ebt_pkg::MODE_FAST_MAX || mode == ebt_pkg::MODE_FAST_CMP;
   endfunction : ebt_is_fast

   function automatic logic ebt_is_pc(input logic [2:0] mode);
      return mode == ebt_pkg::MODE_PC_MAX || mode == ebt_pkg::MODE_PC_CMP;
   endfunction : ebt_is_pc

   // next waveform level for one channel on a count clock
   function automatic logic ebt_wave(input logic [1:0] com, input logic [2:0] mode, input logic match,
                                     input logic wrap, input logic down, input logic cur);
      logic v;
      v = cur;
      if (match) begin
         case (com)
            ebt_pkg::COM_TOGGLE: v = ~cur;
            ebt_pkg::COM_CLEAR: v = (ebt_is_pc(mode) && down) ? 1'b1 : 1'b0;
            ebt_pkg::COM_SET: v = (ebt_is_pc(mode) && down) ? 1'b0 : 1'b1;
            default: v = cur;
         endcase
      end
      // fast pwm restarts the period at bottom, after any match at top
      if (wrap && ebt_is_fast(mode)) begin
         if (com == ebt_pkg::COM_CLEAR) begin
            v = 1'b1;
         end else if (com == ebt_pkg::COM_SET) begin
            v = 1'b0;
         end
      end
      return v;
   endfunction : ebt_wave

   ////////////////////////////////////////////////////////////////////////////
   // count clock selection

   logic [2:0] mode;
   logic [2:0] cs;
   logic [4:0] taps;
   logic tick;
   logic [7:0] top;

   assign mode = {st_reg.ctrl_b[ebt_pkg::WGM_HI_BIT], st_reg.ctrl_a[ebt_pkg::WGM_LO_LSB +: 2]};
   assign cs = st_reg.ctrl_b[ebt_pkg::CS_LSB +: 3];
   assign tk.src_rc = st_reg.shut[ebt_pkg::RC_SRC_BIT];
   assign tk.rc_edge = st_reg.rc_sync[1] && !st_reg.rc_prev;
   assign taps = st_reg.shut[ebt_pkg::SHARE_BIT] ? second_timer_taps : tk.taps;
   assign prescale_taps = tk.taps;

   ebt_prescaler u_pre (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tk(tk)
   );

   always_comb begin
      case (cs)
         ebt_pkg::CS_DIV1: tick = taps[0];
         ebt_pkg::CS_DIV8: tick = taps[1];
         ebt_pkg::CS_DIV64: tick = taps[2];
         ebt_pkg::CS_DIV256: tick = taps[3];
         ebt_pkg::CS_DIV1024: tick = taps[4];
         ebt_pkg::CS_EXT_FALL: tick = st_reg.ext_prev && !st_reg.ext_sync[1];
         ebt_pkg::CS_EXT_RISE: tick = !st_reg.ext_prev && st_reg.ext_sync[1];
         default: tick = 1'b0;
      endcase
   end

   // ceiling follows compare a in the match-clear and compare-topped modes
   assign top = (mode == ebt_pkg::MODE_CLEAR || mode == ebt_pkg::MODE_FAST_CMP || mode == ebt_pkg::MODE_PC_CMP)
                ? st_reg.cmp_a : ebt_pkg::COUNT_MAX;

   ////////////////////////////////////////////////////////////////////////////
   // next state

   logic wr;
   logic rd_setup;
   logic mapped;
   logic pwm;
   logic match_a;
   logic match_b;
   logic wrap;
   logic ovf;
   logic reload;
   logic [2:0] sd_sel;

   always_comb begin
      st_next = st_reg;
      // synchronisers; stage one feeds stage two only
      st_next.ext_sync = {st_reg.ext_sync[0], ext_count_pin};
      st_next.ext_prev = st_reg.ext_sync[1];
      st_next.rc_sync = {st_reg.rc_sync[0], doubled_rc_clock};
      st_next.rc_prev = st_reg.rc_sync[1];
      st_next.trig_s1 = shutdown_trig;
      st_next.trig_s2 = st_reg.trig_s1;

      pwm = ebt_is_fast(mode) || ebt_is_pc(mode);
      match_a = st_reg.cnt == st_reg.cmp_a;
      match_b = st_reg.cnt == st_reg.cmp_b;
      wrap = 1'b0;
      ovf = 1'b0;
      reload = 1'b0;

      if (tick) begin
         if (ebt_is_pc(mode)) begin
            if (!st_reg.dir_down) begin
               if (st_reg.cnt == top) begin
                  reload = 1'b1;
                  if (top != ebt_pkg::COUNT_BOTTOM) begin
                     st_next.dir_down = 1'b1;
                     st_next.cnt = st_reg.cnt - 8'h01;
                  end
               end else begin
                  st_next.cnt = st_reg.cnt + 8'h01;
               end
            end else if (st_reg.cnt == ebt_pkg::COUNT_BOTTOM) begin
               ovf = 1'b1;
               st_next.dir_down = 1'b0;
               st_next.cnt = st_reg.cnt + 8'h01;
            end else begin
               st_next.cnt = st_reg.cnt - 8'h01;
            end
         end else if (ebt_is_fast(mode)) begin
            if (st_reg.cnt == top) begin
               ovf = 1'b1;
               reload = 1'b1;
               wrap = 1'b1;
               st_next.cnt = ebt_pkg::COUNT_BOTTOM;
            end else begin
               st_next.cnt = st_reg.cnt + 8'h01;
            end
         end else if (mode == ebt_pkg::MODE_CLEAR && match_a) begin
            st_next.cnt = ebt_pkg::COUNT_BOTTOM;
         end else begin
            // normal mode, and match-clear running past compare a, wrap at max
            ovf = st_reg.cnt == ebt_pkg::COUNT_MAX;
            st_next.cnt = st_reg.cnt + 8'h01;
         end
         st_next.dir_down = st_next.dir_down && ebt_is_pc(mode);
         st_next.wave_a = ebt_wave(st_reg.ctrl_a[ebt_pkg::COM_A_LSB +: 2], mode, match_a, wrap,
                                   st_reg.dir_down, st_reg.wave_a);
         st_next.wave_b = ebt_wave(st_reg.ctrl_a[ebt_pkg::COM_B_LSB +: 2], mode, match_b, wrap,
                                   st_reg.dir_down, st_reg.wave_b);
      end

      if (reload && pwm) begin
         st_next.cmp_a = st_reg.buf_a;
         st_next.cmp_b = st_reg.buf_b;
      end

      // apb: zero wait states, read data captured in the setup cycle
      wr = psel && penable && pwrite;
      rd_setup = psel && !penable && !pwrite;
      case (paddr)
         ebt_pkg::ADDR_CTRL_A, ebt_pkg::ADDR_CTRL_B, ebt_pkg::ADDR_COUNT, ebt_pkg::ADDR_CMP_A,
         ebt_pkg::ADDR_CMP_B, ebt_pkg::ADDR_FLAGS, ebt_pkg::ADDR_DEAD, ebt_pkg::ADDR_SHUT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase

      if (rd_setup) begin
         case (paddr)
            ebt_pkg::ADDR_CTRL_A: st_next.rdata = {24'h00_0000, st_reg.ctrl_a};
            ebt_pkg::ADDR_CTRL_B: st_next.rdata = {24'h00_0000, st_reg.ctrl_b};
            ebt_pkg::ADDR_COUNT: st_next.rdata = {24'h00_0000, st_reg.cnt};
            ebt_pkg::ADDR_CMP_A: st_next.rdata = {24'h00_0000, pwm ? st_reg.buf_a : st_reg.cmp_a};
            ebt_pkg::ADDR_CMP_B: st_next.rdata = {24'h00_0000, pwm ? st_reg.buf_b : st_reg.cmp_b};
            ebt_pkg::ADDR_FLAGS: st_next.rdata = {29'h0000_0000, st_reg.flags};
            ebt_pkg::ADDR_DEAD: st_next.rdata = {24'h00_0000, st_reg.dead};
            ebt_pkg::ADDR_SHUT: st_next.rdata = {24'h00_0000, st_reg.shut};
            default: st_next.rdata = 32'h0000_0000;
         endcase
      end

      if (wr) begin
         case (paddr)
            ebt_pkg::ADDR_CTRL_A: st_next.ctrl_a = pwdata[7:0];
            ebt_pkg::ADDR_CTRL_B: st_next.ctrl_b = pwdata[7:0];
            ebt_pkg::ADDR_COUNT: st_next.cnt = pwdata[7:0];
            ebt_pkg::ADDR_CMP_A: begin
               st_next.buf_a = pwdata[7:0];
               if (!pwm) begin
                  st_next.cmp_a = pwdata[7:0];
               end
            end
            ebt_pkg::ADDR_CMP_B: begin
               st_next.buf_b = pwdata[7:0];
               if (!pwm) begin
                  st_next.cmp_b = pwdata[7:0];
               end
            end
            ebt_pkg::ADDR_FLAGS: st_next.flags = st_reg.flags & ~pwdata[2:0];
            ebt_pkg::ADDR_DEAD: st_next.dead = pwdata[7:0];
            ebt_pkg::ADDR_SHUT: st_next.shut = pwdata[7:0];
            default: st_next.flags = st_next.flags;
         endcase
      end

      // flags are set after the clear so a same-cycle event is never lost
      if (tick) begin
         st_next.flags[ebt_pkg::FLAG_CMP_A] = st_next.flags[ebt_pkg::FLAG_CMP_A] | match_a;
         st_next.flags[ebt_pkg::FLAG_CMP_B] = st_next.flags[ebt_pkg::FLAG_CMP_B] | match_b;
      end
      st_next.flags[ebt_pkg::FLAG_OVF] = st_next.flags[ebt_pkg::FLAG_OVF] | ovf;

      // hardware shutdown overrides a software write in the same cycle
      sd_sel = st_reg.shut[ebt_pkg::SD_SRC_LSB +: 3];
      if (st_reg.shut[ebt_pkg::SD_EN_BIT] && sd_sel < 3'(ebt_pkg::NUM_TRIG) && st_reg.trig_s2[sd_sel]) begin
         st_next.ctrl_a[ebt_pkg::COM_A_LSB +: 2] = ebt_pkg::COM_OFF;
         st_next.ctrl_a[ebt_pkg::COM_B_LSB +: 2] = ebt_pkg::COM_OFF;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign prdata = st_reg.rdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // pin direction is the caller's business; oe only says the timer owns it
   assign waveform_out_a_oe = st_reg.ctrl_a[ebt_pkg::COM_A_LSB +: 2] != ebt_pkg::COM_OFF;
   assign waveform_out_b_oe = st_reg.ctrl_a[ebt_pkg::COM_B_LSB +: 2] != ebt_pkg::COM_OFF;

   ebt_dead_time u_dt_a (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(tick),
      .enable(st_reg.ctrl_b[ebt_pkg::DT_EN_BIT]),
      .dead_count(st_reg.dead),
      .wave_in(st_reg.wave_a),
      .wave_out(waveform_out_a)
   );

   ebt_dead_time u_dt_b (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(tick),
      .enable(st_reg.ctrl_b[ebt_pkg::DT_EN_BIT]),
      .dead_count(st_reg.dead),
      .wave_in(st_reg.wave_b),
      .wave_out(waveform_out_b)
   );
endmodule : ebt_timer

// ===== ebt_pkg.sv
package ebt_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] ADDR_CTRL_A = 8'h00;
   localparam logic [7:0] ADDR_CTRL_B = 8'h04;
   localparam logic [7:0] ADDR_COUNT = 8'h08;
   localparam logic [7:0] ADDR_CMP_A = 8'h0C;
   localparam logic [7:0] ADDR_CMP_B = 8'h10;
   localparam logic [7:0] ADDR_FLAGS = 8'h14;
   localparam logic [7:0] ADDR_DEAD = 8'h18;
   localparam logic [7:0] ADDR_SHUT = 8'h1C;

   // control_register_a fields
   localparam int COM_A_LSB = 6;
   localparam int COM_B_LSB = 4;
   localparam int WGM_LO_LSB = 0;
   // control_register_b fields
   localparam int WGM_HI_BIT = 3;
   localparam int CS_LSB = 0;
   localparam int DT_EN_BIT = 4;
   // shutdown/clocking control fields
   localparam int SD_SRC_LSB = 0;
   localparam int SD_EN_BIT = 3;
   localparam int SHARE_BIT = 4;
   localparam int RC_SRC_BIT = 5;
   localparam int NUM_TRIG = 6;
   // timer_flag_register fields
   localparam int FLAG_OVF = 0;
   localparam int FLAG_CMP_A = 1;
   localparam int FLAG_CMP_B = 2;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;

   // waveform_mode_field codes
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_PC_MAX = 3'h1;
   localparam logic [2:0] MODE_CLEAR = 3'h2;
   localparam logic [2:0] MODE_FAST_MAX = 3'h3;
   localparam logic [2:0] MODE_PC_CMP = 3'h5;
   localparam logic [2:0] MODE_FAST_CMP = 3'h7;

   // clock_select_field codes
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // output_mode codes
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;

   // prescaler width and tap masks
   localparam int PRE_WIDTH = 10;
   localparam logic [9:0] PRE_MASK_8 = 10'h007;
   localparam logic [9:0] PRE_MASK_64 = 10'h03F;
   localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
   localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
   localparam int NUM_TAPS = 5;
endpackage : ebt_pkg

// ===== ebt_tick_if.sv
`timescale 1ns/1ps
interface ebt_tick_if;
   logic src_rc;
   logic rc_edge;
   logic [4:0] taps;
   modport pre (input src_rc, input rc_edge, output taps);
   modport core (output src_rc, output rc_edge, input taps);
endinterface : ebt_tick_if

// ===== ebt_prescaler.sv
`timescale 1ns/1ps
module ebt_prescaler (
   input wire logic mclk,
   input wire logic sys_rst,
   ebt_tick_if.pre tk
);
   logic [ebt_pkg::PRE_WIDTH-1:0] cnt_reg;
   logic [ebt_pkg::PRE_WIDTH-1:0] cnt_next;
   logic src_tick;

   // the rc source arrives as synchronised edges, so both sources run on mclk
   assign src_tick = tk.src_rc ? tk.rc_edge : 1'b1;

   always_comb begin
      cnt_next = cnt_reg;
      if (src_tick) begin
         cnt_next = cnt_reg + 10'h001;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // one-cycle enable per divided period
   assign tk.taps[0] = src_tick;
   assign tk.taps[1] = src_tick && ((cnt_reg & ebt_pkg::PRE_MASK_8) == ebt_pkg::PRE_MASK_8);
   assign tk.taps[2] = src_tick && ((cnt_reg & ebt_pkg::PRE_MASK_64) == ebt_pkg::PRE_MASK_64);
   assign tk.taps[3] = src_tick && ((cnt_reg & ebt_pkg::PRE_MASK_256) == ebt_pkg::PRE_MASK_256);
   assign tk.taps[4] = src_tick && (cnt_reg == ebt_pkg::PRE_MASK_1024);
endmodule : ebt_prescaler

// ===== ebt_dead_time.sv
`timescale 1ns/1ps
module ebt_dead_time (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic enable,
   input wire logic [7:0] dead_count,
   input wire logic wave_in,
   output logic wave_out
);
   typedef struct packed {
      logic [7:0] left;
      logic prev;
      logic out;
   } ebt_dt_s;
   ebt_dt_s st_reg;
   ebt_dt_s st_next;

   always_comb begin
      st_next = st_reg;
      st_next.prev = wave_in;
      if (!enable || dead_count == 8'h00) begin
         st_next.out = wave_in;
         st_next.left = 8'h00;
      end else if (!wave_in) begin
         // falling edges pass at once; only the turn-on is held back
         st_next.out = 1'b0;
         st_next.left = 8'h00;
      end else if (!st_reg.prev) begin
         st_next.left = dead_count;
      end else if (st_reg.left != 8'h00) begin
         if (tick) begin
            st_next.left = st_reg.left - 8'h01;
         end
      end else begin
         st_next.out = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign wave_out = st_reg.out;
endmodule : ebt_dead_time

// ===== ebt_timer_sva.sv
`timescale 1ns/1ps
module ebt_timer_sva (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic doubled_rc_clock,
   input wire logic ext_count_pin,
   input wire logic [5:0] shutdown_trig,
   input wire logic [4:0] second_timer_taps,
   input wire logic [4:0] prescale_taps,
   input wire logic waveform_out_a,
   input wire logic waveform_out_a_oe,
   input wire logic waveform_out_b,
   input wire logic waveform_out_b_oe
);
   // shadow of the shutdown control, rebuilt from bus writes
   logic [7:0] sd_ctl_reg;
   logic [7:0] sd_ctl_next;
   always_comb begin
      sd_ctl_next = sd_ctl_reg;
      if (psel && penable && pwrite && paddr == ebt_pkg::ADDR_SHUT) begin
         sd_ctl_next = pwdata[7:0];
      end
   end
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sd_ctl_reg <= 8'h00;
      end else begin
         sd_ctl_reg <= sd_ctl_next;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////
   a_reset_zero: assert property ($fell(sys_rst) |-> prdata == 32'h0 && !waveform_out_a_oe &&
      !waveform_out_b_oe && !waveform_out_a && !waveform_out_b) else $error("state not cleared by reset");
   a_tap_nest: assert property (prescale_taps[2] |-> prescale_taps[1:0] == 2'b11)
      else $error("divide taps not nested");
   a_tap_gap: assert property (prescale_taps[1] |=> !prescale_taps[1] [*7])
      else $error("divide by eight tap too frequent");
   a_ready_high: assert property (psel |-> pready) else $error("bus not ready");
   a_err_unmapped: assert property (psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > ebt_pkg::ADDR_SHUT))
      else $error("bus error flag wrong");
   a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data changed outside a read");
   a_oe_off_a: assert property (psel && penable && pwrite && paddr == ebt_pkg::ADDR_CTRL_A &&
      pwdata[7:6] == 2'b00 |=> !waveform_out_a_oe) else $error("channel a still driven");
   a_oe_off_b: assert property (psel && penable && pwrite && paddr == ebt_pkg::ADDR_CTRL_A &&
      pwdata[5:4] == 2'b00 |=> !waveform_out_b_oe) else $error("channel b still driven");
   a_shut_clear: assert property ((sd_ctl_reg[3] && shutdown_trig[sd_ctl_reg[2:0]]) [*3] |->
      ##[0:2] (!waveform_out_a_oe && !waveform_out_b_oe)) else $error("shutdown did not stop outputs");
endmodule : ebt_timer_sva

bind ebt_timer ebt_timer_sva u_sva (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .doubled_rc_clock, .ext_count_pin, .shutdown_trig, .second_timer_taps, .prescale_taps,
   .waveform_out_a, .waveform_out_a_oe, .waveform_out_b, .waveform_out_b_oe);

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] drv = 3'b000;
   logic [5:0] shutdown_trig = 6'h00;
   logic [4:0] prescale_taps;
   logic waveform_out_a, waveform_out_a_oe, waveform_out_b, waveform_out_b_oe;
   wire ext_count_pin = drv[0];
   wire doubled_rc_clock = drv[1];
   wire [4:0] second_timer_taps = {4'h0, drv[2]};
   logic [31:0] rd;
   logic err;
   int mismatches = 0;
   int n_checks = 0;
   always #4 mclk = ~mclk;
   ebt_timer u_dut (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .doubled_rc_clock, .ext_count_pin, .shutdown_trig, .second_timer_taps, .prescale_taps,
      .waveform_out_a, .waveform_out_a_oe, .waveform_out_b, .waveform_out_b_oe);
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // a value within tol of exp counts as exp
   task automatic near(input string what, input int seen, input int exp, input int tol);
      check(what, 32'((seen >= exp - tol && seen <= exp + tol) ? exp : seen), 32'(exp));
   endtask : near
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // only the watchdog ends a hung transfer
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr
   task automatic start(input logic [2:0] m, input logic [2:0] cs, input logic [7:0] com, input logic [7:0] cnt,
                        input logic dt);
      wr(ebt_pkg::ADDR_CTRL_B, 8'h00);
      wr(ebt_pkg::ADDR_CTRL_A, com | {6'h0, m[1:0]});
      wr(ebt_pkg::ADDR_COUNT, cnt);
      wr(ebt_pkg::ADDR_CTRL_B, {3'h0, dt, m[2], cs});
   endtask : start
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      for (int a = 0; a <= 'h24; a += 4) begin
         apb(1'b0, 8'(a), 32'h0);
         check("reset value", rd, 32'h0);
         check("bus error", 32'(err), 32'(a > 'h1C));
      end
   endtask : t_reset
   task automatic t_modes;
      logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
      logic [7:0] mx;
      start(3'h0, ebt_pkg::CS_STOP, 8'h00, 8'h00, 1'b0);
      wr(ebt_pkg::ADDR_CMP_A, 8'h0F);
      foreach (modes[i]) begin
         mx = 8'h00;
         start(modes[i], ebt_pkg::CS_DIV1, 8'h00, 8'h00, 1'b0);
         repeat (25) begin
            apb(1'b0, ebt_pkg::ADDR_COUNT, 32'h0);
            mx = (rd[7:0] > mx) ? rd[7:0] : mx;
         end
         check("above compare a", 32'(mx > 8'h0F), 32'(modes[i] inside {3'h0, 3'h1, 3'h3}));
      end
   endtask : t_modes
   task automatic t_flags;
      start(3'h0, ebt_pkg::CS_STOP, 8'h00, 8'hFD, 1'b0);
      wr(ebt_pkg::ADDR_CMP_A, 8'h00);
      wr(ebt_pkg::ADDR_CMP_B, 8'h80);
      wr(ebt_pkg::ADDR_FLAGS, 8'h07);
      wr(ebt_pkg::ADDR_CTRL_B, {5'h0, ebt_pkg::CS_DIV1});
      repeat (4) @(posedge mclk);
      wr(ebt_pkg::ADDR_CTRL_B, 8'h00);
      apb(1'b0, ebt_pkg::ADDR_FLAGS, 32'h0);
      check("flags after wrap", rd, 32'h3);
      wr(ebt_pkg::ADDR_FLAGS, 8'h01);
      apb(1'b0, ebt_pkg::ADDR_FLAGS, 32'h0);
      check("flags after clear", rd, 32'h2);
   endtask : t_flags
   // pwm compare writes stay buffered until the count passes top
   task automatic t_buffer;
      int runs [3] = '{16, 234, 16};
      logic [31:0] flg [3] = '{32'h0, 32'h1, 32'h7};
      start(ebt_pkg::MODE_NORMAL, ebt_pkg::CS_STOP, 8'h00, 8'h10, 1'b0);
      wr(ebt_pkg::ADDR_CMP_A, 8'h08);
      wr(ebt_pkg::ADDR_CMP_B, 8'h0C);
      start(ebt_pkg::MODE_FAST_MAX, ebt_pkg::CS_STOP, 8'h00, 8'h10, 1'b0);
      wr(ebt_pkg::ADDR_CMP_A, 8'h18);
      wr(ebt_pkg::ADDR_CMP_B, 8'h1C);
      wr(ebt_pkg::ADDR_FLAGS, 8'h07);
      foreach (runs[i]) begin
         wr(ebt_pkg::ADDR_CTRL_B, {5'h0, ebt_pkg::CS_DIV1});
         repeat (runs[i]) @(posedge mclk);
         wr(ebt_pkg::ADDR_CTRL_B, 8'h00);
         apb(1'b0, ebt_pkg::ADDR_FLAGS, 32'h0);
         check("buffered compares", rd, flg[i]);
      end
   endtask : t_buffer
   // channel a cleared on up-count match, set at bottom (fast pwm) or on down-count match (phase correct); count high cycles
   task automatic t_duty(input logic [2:0] m, input logic [7:0] cmp, input logic [7:0] dt, input int n, input int exp);
      int hi;
      hi = 0;
      start(3'h0, ebt_pkg::CS_STOP, 8'h00, 8'h00, 1'b0);
      wr(ebt_pkg::ADDR_CMP_A, cmp);
      wr(ebt_pkg::ADDR_DEAD, dt);
      start(m, ebt_pkg::CS_DIV1, 8'h80, 8'h00, dt != 8'h00);
      repeat (600) @(posedge mclk);
      repeat (n) begin
         @(posedge mclk);
         hi += int'(waveform_out_a);
      end
      near("high time", hi, exp, 8);
      check("drive a on", 32'(waveform_out_a_oe), 32'h1);
      wr(ebt_pkg::ADDR_CTRL_A, {6'h0, m[1:0]});
      check("drive a off", 32'(waveform_out_a_oe), 32'h0);
   endtask : t_duty
   task automatic t_shut;
      for (int s = 0; s < ebt_pkg::NUM_TRIG; s++) begin
         wr(ebt_pkg::ADDR_SHUT, 8'(8 + s));
         wr(ebt_pkg::ADDR_CTRL_A, 8'hF0);
         shutdown_trig <= 6'(1 << ((s + 1) % 6));
         repeat (6) @(posedge mclk);
         apb(1'b0, ebt_pkg::ADDR_CTRL_A, 32'h0);
         check("other source ignored", rd, 32'hF0);
         shutdown_trig <= 6'(1 << s);
         repeat (6) @(posedge mclk);
         apb(1'b0, ebt_pkg::ADDR_CTRL_A, 32'h0);
         check("modes cleared", rd, 32'h0);
         check("outputs off", 32'({waveform_out_a_oe, waveform_out_b_oe}), 32'h0);
         shutdown_trig <= 6'h00;
         repeat (4) @(posedge mclk);
      end
      wr(ebt_pkg::ADDR_SHUT, 8'h00);
   endtask : t_shut
   task automatic t_divide;
      for (int k = 2; k <= 5; k++) begin
         start(3'h0, 3'(k), 8'h00, 8'h00, 1'b0);
         repeat (6 * (1 << (3 * k - 3 - (k > 3 ? k - 3 : 0) * 1))) @(posedge mclk);
         wr(ebt_pkg::ADDR_CTRL_B, 8'h00);
         apb(1'b0, ebt_pkg::ADDR_COUNT, 32'h0);
         near("divided count", int'(rd), 6, 1);
      end
   endtask : t_divide
   // sel 0 external pin, 1 rc clock, 2 other timer's tap
   task automatic t_pulse(input logic [7:0] shut, input logic [2:0] cs, input int sel, input int n);
      wr(ebt_pkg::ADDR_SHUT, shut);
      start(3'h0, cs, 8'h00, 8'h00, 1'b0);
      repeat (n) begin
         drv <= 3'(1 << sel);
         @(posedge mclk);
         drv <= 3'b000;
         repeat (3) @(posedge mclk);
      end
      repeat (4) @(posedge mclk);
      apb(1'b0, ebt_pkg::ADDR_COUNT, 32'h0);
      check("counted edges", rd, 32'(n));
      wr(ebt_pkg::ADDR_CTRL_B, 8'h00);
      wr(ebt_pkg::ADDR_SHUT, 8'h00);
   endtask : t_pulse
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      t_reset();
      t_modes();
      t_flags();
      t_buffer();
      t_duty(ebt_pkg::MODE_FAST_MAX, 8'h80, 8'h00, 1024, 512);
      t_duty(ebt_pkg::MODE_FAST_MAX, 8'h80, 8'h04, 1024, 496);
      t_duty(ebt_pkg::MODE_PC_MAX, 8'h40, 8'h00, 1020, 256);
      t_shut();
      t_divide();
      t_pulse(8'h00, ebt_pkg::CS_EXT_RISE, 0, 5);
      t_pulse(8'h00, ebt_pkg::CS_EXT_FALL, 0, 5);
      t_pulse(8'h20, ebt_pkg::CS_DIV1, 1, 6);
      t_pulse(8'h10, ebt_pkg::CS_DIV1, 2, 3);
      close_out();
   end
   initial begin
      repeat (60000) @(posedge mclk);
      mismatches++;
      close_out();
   end
endmodule : tb_top
